/* File: core/ckpm_pkg.sv */
// package: constants, register map and types of the clock and power-mode controller
package ckpm_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_MHZ         = 125;
	localparam int unsigned XTAL_WAIT_US    = 100;
	localparam int unsigned XTAL_WAIT_CYC   = XTAL_WAIT_US * CLK_MHZ;
	localparam int unsigned POR_HOLD_CYC    = 16;
	localparam int unsigned LSI_DIV_DEFAULT = 8333;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_CLK_STOP  = 8'h00;
	localparam logic [7:0] ADDR_HSI_FREQ  = 8'h04;
	localparam logic [7:0] ADDR_CPU_CLK   = 8'h08;
	localparam logic [7:0] ADDR_PWR_KEY   = 8'h0C;
	localparam logic [7:0] ADDR_WAKE_MASK = 8'h10;
	localparam logic [7:0] ADDR_STATUS    = 8'h14;
	localparam logic [7:0] ADDR_CMD       = 8'h18;

	// clk_stop fields
	localparam int unsigned BIT_MAIN_STOP = 0;
	localparam int unsigned BIT_HSI_STOP  = 1;
	localparam int unsigned BIT_SUB_STOP  = 2;
	localparam logic [2:0]  CLK_STOP_RST  = 3'h4;

	// cmd fields
	localparam int unsigned BIT_CMD_SLEEP = 0;
	localparam int unsigned BIT_CMD_DEEP  = 1;

	localparam logic [31:0] PWR_KEY_VALUE = 32'h0000_A5C3;

	// wake sources
	localparam int unsigned WAKE_W     = 7;
	localparam int unsigned W_EXT      = 0;
	localparam int unsigned W_KEY      = 1;
	localparam int unsigned W_RTC      = 2;
	localparam int unsigned W_ITMR     = 3;
	localparam int unsigned W_WDT      = 4;
	localparam int unsigned W_LVD      = 5;
	localparam int unsigned W_OTHER    = 6;
	localparam logic [6:0]  PPD_WAKE   = 7'h3F;
	localparam logic [6:0]  WMASK_RST  = 7'h00;

	// cpu clock source
	typedef enum logic [1:0] {
		CKPM_SRC_HSI  = 2'h0,
		CKPM_SRC_MAIN = 2'h1,
		CKPM_SRC_SUB  = 2'h2,
		CKPM_SRC_LSI  = 2'h3
	} ckpm_src_t;

	// power mode, gray along run-sleep-deep-ppd
	typedef enum logic [2:0] {
		CKPM_RUN   = 3'h0,
		CKPM_SLEEP = 3'h1,
		CKPM_DEEP  = 3'h3,
		CKPM_PPD   = 3'h2,
		CKPM_STAB  = 3'h6
	} ckpm_mode_t;
endpackage

/* File: core/ckpm_ctl_if.sv */
// interface: gating requests between mode controller and clock gate cells
`timescale 1ns/1ps
`default_nettype none
interface ckpm_ctl_if;
	logic cpu_en;
	logic per_en;
	modport ctl  (output cpu_en, output per_en);
	modport gate (input cpu_en, input per_en);
endinterface
`default_nettype wire

/* File: core/ckpm_gate.sv */
// module: glitch-free clock enable gate with a divider enable
`timescale 1ns/1ps
`default_nettype none
module ckpm_gate
	import ckpm_pkg::*;
#(
	parameter int unsigned DIV = LSI_DIV_DEFAULT
) (
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic arst_n_i,
	// control
	input  wire logic en_i,
	input  wire logic osc_on_i,
	// output enable pulse
	output logic      tick_o
);
	logic [15:0] cnt_reg;
	logic        en_reg;
	wire         wrap = (cnt_reg == 16'(DIV - 1));

	// enable changes only at a divider boundary, so no partial pulse leaves
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_reg <= 16'h0000;
			en_reg  <= 1'b0;
		end else if (osc_on_i) begin
			cnt_reg <= wrap ? 16'h0000 : cnt_reg + 16'h0001;
			if (wrap) begin
				en_reg <= en_i;
			end
		end
	end

	assign tick_o = en_reg && osc_on_i && wrap;
endmodule
`default_nettype wire

/* File: core/ckpm_top.sv */
// module: clock source and low-power mode controller with wishbone registers
// What this block does
// - main crystal halts on deep sleep or main_osc_stop_bit; range 1 to 20 MHz.
// - after reset the cpu runs from the fast internal oscillator at option frequency.
// - fast internal oscillator stops on deep sleep or fast_internal_osc_stop_bit.
// - software may overwrite the option frequency of the fast oscillator, max 64 MHz.
// - external main clock input blocked on deep sleep or main_osc_stop_bit.
// - sub crystal and external sub clock stop while sub_osc_stop_bit is set.
// - the 15 kHz slow oscillator can clock cpu, watchdog, rtc and interval timer.
// - internal reset held at power-on, reasserted when supply drops below threshold.
// - low-voltage detector gives reset or interrupt by option; works in deep sleep.
// - sleep gates only the cpu clock; running oscillators keep running.
// - any unmasked interrupt ends sleep at once, with no oscillator wait.
// - deep sleep stops fast oscillators and whole system; interrupt wakes it.
// - waking from deep sleep on main crystal waits for oscillator settling.
// - power_unit_key then deep sleep powers down secondary_ram_bank and peripherals.
// - partial power-down ends only on pin, key, rtc, interval timer, watchdog or detector.
// - watchdog and detector wake partial power-down only in interrupt mode.
// - sleep and deep sleep without power_unit_key keep registers, flags, memory and port states.
// - external reset pin ignored during partial power-down deep sleep.
`timescale 1ns/1ps
`default_nettype none
module ckpm_top
	import ckpm_pkg::*;
#(
	parameter int unsigned STAB_CYC = XTAL_WAIT_CYC,
	parameter int unsigned LSI_DIV  = LSI_DIV_DEFAULT
) (
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        arst_n_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// supply monitors and option byte
	input  wire logic        por_ok_i,
	input  wire logic        lvd_low_i,
	input  wire logic        opt_lvd_irq_mode_i,
	input  wire logic        opt_wdt_irq_mode_i,
	input  wire logic [7:0]  opt_hsi_freq_i,
	input  wire logic        ext_reset_n_i,
	// interrupt sources
	input  wire logic [6:0]  irq_src_i,
	// oscillator controls
	output logic             main_osc_en_o,
	output logic             main_ext_in_en_o,
	output logic             hsi_osc_en_o,
	output logic [7:0]       hsi_freq_o,
	output logic             sub_osc_en_o,
	output logic             sub_ext_in_en_o,
	output logic             lsi_osc_en_o,
	// clock gating and power
	output logic             cpu_clk_en_o,
	output logic             per_clk_en_o,
	output logic             lsi_tick_o,
	output logic [1:0]       cpu_src_o,
	output logic             secondary_ram_bank_pwr_en_o,
	output logic             per_pwr_en_o,
	output logic             sys_rst_n_o,
	output logic             lvd_irq_o,
	output logic             reinit_req_o
);
	// ****************************************
	// power-on and detector reset
	// ****************************************
	logic [4:0] por_cnt_reg;
	logic       rst_n_reg;
	logic       ppd_active;
	wire        lvd_rst   = lvd_low_i && !opt_lvd_irq_mode_i;
	wire        ext_rst   = !ext_reset_n_i && !ppd_active;
	wire        rst_cause = !por_ok_i || lvd_rst || ext_rst;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			por_cnt_reg <= 5'h00;
			rst_n_reg   <= 1'b0;
		end else if (rst_cause) begin
			por_cnt_reg <= 5'h00;
			rst_n_reg   <= 1'b0;
		end else if (por_cnt_reg != 5'(POR_HOLD_CYC)) begin
			por_cnt_reg <= por_cnt_reg + 5'h01;
		end else begin
			rst_n_reg   <= 1'b1;
		end
	end
	assign sys_rst_n_o = rst_n_reg;
	wire srst = !rst_n_reg;

	// ****************************************
	// registers
	// ****************************************
	logic [2:0]  stop_reg;
	logic [7:0]  hsi_freq_reg;
	logic        hsi_freq_set_reg;
	ckpm_src_t   src_reg;
	logic        key_reg;
	logic [6:0]  wmask_reg;
	ckpm_mode_t  mode_reg;
	ckpm_mode_t  mode_next;
	logic [23:0] stab_cnt_reg;
	logic        reinit_reg;
	logic        lvd_irq_reg;
	logic        ack_reg;
	logic [31:0] dat_reg;

	wire req       = wb_cyc_i && wb_stb_i && !ack_reg;
	wire wr        = req && wb_we_i;
	wire sel_stop  = (wb_adr_i == ADDR_CLK_STOP);
	wire sel_freq  = (wb_adr_i == ADDR_HSI_FREQ);
	wire sel_src   = (wb_adr_i == ADDR_CPU_CLK);
	wire sel_key   = (wb_adr_i == ADDR_PWR_KEY);
	wire sel_mask  = (wb_adr_i == ADDR_WAKE_MASK);
	wire sel_stat  = (wb_adr_i == ADDR_STATUS);
	wire sel_cmd   = (wb_adr_i == ADDR_CMD);
	wire wr_b0     = wr && wb_sel_i[0];
	wire cmd_sleep = wr_b0 && sel_cmd && wb_dat_i[BIT_CMD_SLEEP] && (mode_reg == CKPM_RUN);
	wire cmd_deep  = wr_b0 && sel_cmd && wb_dat_i[BIT_CMD_DEEP] && (mode_reg == CKPM_RUN);
	wire key_ok    = (wb_dat_i == PWR_KEY_VALUE) && (wb_sel_i == 4'hF);

	// ****************************************
	// wake logic
	// ****************************************
	wire [6:0] ppd_allow = PPD_WAKE & {1'b1, opt_lvd_irq_mode_i, opt_wdt_irq_mode_i, 4'hF};
	wire [6:0] pend      = irq_src_i & wmask_reg;
	wire       wake_any  = |pend;
	wire       wake_ppd  = |(pend & ppd_allow);
	assign ppd_active = (mode_reg == CKPM_PPD);
	wire       need_stab = (src_reg == CKPM_SRC_MAIN);

	// ****************************************
	// mode state machine
	// ****************************************
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			CKPM_RUN: begin
				if (cmd_deep) begin
					mode_next = key_reg ? CKPM_PPD : CKPM_DEEP;
				end else if (cmd_sleep) begin
					mode_next = CKPM_SLEEP;
				end
			end
			CKPM_SLEEP: begin
				if (wake_any) begin
					mode_next = CKPM_RUN;
				end
			end
			CKPM_DEEP: begin
				if (wake_any) begin
					mode_next = need_stab ? CKPM_STAB : CKPM_RUN;
				end
			end
			CKPM_PPD: begin
				if (wake_ppd) begin
					mode_next = need_stab ? CKPM_STAB : CKPM_RUN;
				end
			end
			CKPM_STAB: begin
				if (stab_cnt_reg == 24'(STAB_CYC - 1)) begin
					mode_next = CKPM_RUN;
				end
			end
			default: begin
				mode_next = CKPM_RUN;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_reg     <= CKPM_RUN;
			stab_cnt_reg <= 24'h000000;
		end else if (srst) begin
			mode_reg     <= CKPM_RUN;
			stab_cnt_reg <= 24'h000000;
		end else begin
			mode_reg     <= mode_next;
			stab_cnt_reg <= (mode_reg == CKPM_STAB) ? stab_cnt_reg + 24'h000001 : 24'h000000;
		end
	end

	// ****************************************
	// software registers; kept through sleep and deep sleep
	// ****************************************
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stop_reg         <= CLK_STOP_RST;
			hsi_freq_reg     <= 8'h00;
			hsi_freq_set_reg <= 1'b0;
			src_reg          <= CKPM_SRC_HSI;
			key_reg          <= 1'b0;
			wmask_reg        <= WMASK_RST;
			reinit_reg       <= 1'b0;
			lvd_irq_reg      <= 1'b0;
		end else if (srst) begin
			stop_reg         <= CLK_STOP_RST;
			hsi_freq_set_reg <= 1'b0;
			src_reg          <= CKPM_SRC_HSI;
			key_reg          <= 1'b0;
			wmask_reg        <= WMASK_RST;
			reinit_reg       <= 1'b0;
			lvd_irq_reg      <= 1'b0;
		end else begin
			if (wr_b0 && sel_stop) begin
				stop_reg <= wb_dat_i[2:0];
			end
			if (wr_b0 && sel_freq) begin
				hsi_freq_reg     <= wb_dat_i[7:0];
				hsi_freq_set_reg <= 1'b1;
			end
			if (wr_b0 && sel_src) begin
				src_reg <= ckpm_src_t'(wb_dat_i[1:0]);
			end
			if (wr && sel_key) begin
				key_reg <= key_ok;
			end else if (cmd_deep) begin
				key_reg <= 1'b0;
			end
			if (wr_b0 && sel_mask) begin
				wmask_reg <= wb_dat_i[6:0];
			end
			// set wins over clear
			if (mode_reg == CKPM_PPD && mode_next != CKPM_PPD) begin
				reinit_reg <= 1'b1;
			end else if (wr_b0 && sel_stat && wb_dat_i[0]) begin
				reinit_reg <= 1'b0;
			end
			if (lvd_low_i && opt_lvd_irq_mode_i) begin
				lvd_irq_reg <= 1'b1;
			end else if (wr_b0 && sel_stat && wb_dat_i[1]) begin
				lvd_irq_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// wishbone answer, one cycle after request
	// ****************************************
	wire [31:0] rd_mux =
		sel_stop ? {29'h0, stop_reg} :
		sel_freq ? {24'h0, hsi_freq_o} :
		sel_src  ? {30'h0, src_reg} :
		sel_key  ? {31'h0, key_reg} :
		sel_mask ? {25'h0, wmask_reg} :
		sel_stat ? {27'h0, mode_reg, lvd_irq_reg, reinit_reg} :
		32'h0000_0000;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req;
			if (req && !wb_we_i) begin
				dat_reg <= rd_mux;
			end
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	// ****************************************
	// oscillator enables and power
	// ****************************************
	wire deep_like = (mode_reg == CKPM_DEEP) || (mode_reg == CKPM_PPD);
	assign main_osc_en_o    = !stop_reg[BIT_MAIN_STOP] && !deep_like;
	assign main_ext_in_en_o = !stop_reg[BIT_MAIN_STOP] && !deep_like;
	assign hsi_osc_en_o     = !stop_reg[BIT_HSI_STOP] && !deep_like;
	assign sub_osc_en_o     = !stop_reg[BIT_SUB_STOP];
	assign sub_ext_in_en_o  = !stop_reg[BIT_SUB_STOP];
	assign lsi_osc_en_o     = 1'b1;
	assign hsi_freq_o       = hsi_freq_set_reg ? hsi_freq_reg : opt_hsi_freq_i;
	assign cpu_src_o        = src_reg;
	assign secondary_ram_bank_pwr_en_o    = !ppd_active;
	assign per_pwr_en_o     = !ppd_active;
	assign lvd_irq_o        = lvd_irq_reg;
	assign reinit_req_o     = reinit_reg;

	// ****************************************
	// clock gating, registers and memory kept in all but ppd
	// ****************************************
	ckpm_ctl_if ctl ();
	assign ctl.cpu_en = rst_n_reg && (mode_reg == CKPM_RUN);
	assign ctl.per_en = rst_n_reg && !deep_like && (mode_reg != CKPM_STAB);

	logic cpu_en_reg;
	logic per_en_reg;
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cpu_en_reg <= 1'b0;
			per_en_reg <= 1'b0;
		end else begin
			cpu_en_reg <= ctl.cpu_en;
			per_en_reg <= ctl.per_en;
		end
	end
	assign cpu_clk_en_o = cpu_en_reg;
	assign per_clk_en_o = per_en_reg;

	ckpm_gate #(
		.DIV (LSI_DIV)
	) u_lsi (
		.sys_clk_i (sys_clk_i),
		.arst_n_i  (arst_n_i),
		.en_i      (1'b1),
		.osc_on_i  (lsi_osc_en_o),
		.tick_o    (lsi_tick_o)
	);
endmodule
`default_nettype wire

/* File: dv/ckpm_top_monitor.sv */
// checker: concurrent assertions on the ports of the clock and power-mode controller
`timescale 1ns/1ps
`default_nettype none
module ckpm_top_monitor
	import ckpm_pkg::*;
#(
	parameter int unsigned STAB_CYC = XTAL_WAIT_CYC,
	parameter int unsigned LSI_DIV  = LSI_DIV_DEFAULT
) (
	// clock, reset and bus
	input wire logic       sys_clk_i,
	input wire logic       arst_n_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	// supply and option inputs
	input wire logic       por_ok_i,
	input wire logic       lvd_low_i,
	input wire logic       opt_lvd_irq_mode_i,
	// clock and power outputs
	input wire logic       main_osc_en_o,
	input wire logic       main_ext_in_en_o,
	input wire logic       hsi_osc_en_o,
	input wire logic       sub_osc_en_o,
	input wire logic       sub_ext_in_en_o,
	input wire logic       cpu_clk_en_o,
	input wire logic       per_clk_en_o,
	input wire logic       lsi_tick_o,
	input wire logic [1:0] cpu_src_o,
	input wire logic       secondary_ram_bank_pwr_en_o,
	input wire logic       sys_rst_n_o,
	input wire logic       lvd_irq_o
);
	logic [15:0] stab_cnt_reg;
	logic [7:0]  gap_reg;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stab_cnt_reg <= 16'h0;
			gap_reg      <= 8'hFF;
		end else begin
			if ($rose(main_osc_en_o) && !cpu_clk_en_o && cpu_src_o == CKPM_SRC_MAIN)
				stab_cnt_reg <= 16'h1;
			else if (stab_cnt_reg != 16'h0 && stab_cnt_reg < 16'h00FF)
				stab_cnt_reg <= stab_cnt_reg + 16'h1;
			else
				stab_cnt_reg <= 16'h0;
			gap_reg <= lsi_tick_o ? 8'h1 : (gap_reg == 8'hFF ? gap_reg : gap_reg + 8'h1);
		end
	end

	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	a_main_pair: assert property (main_osc_en_o == main_ext_in_en_o)
		else $error("main crystal and external main input disagree");
	a_sub_pair: assert property (sub_osc_en_o == sub_ext_in_en_o)
		else $error("sub crystal and external sub input disagree");
	a_deep_stop: assert property (
		sys_rst_n_o && $fell(per_clk_en_o) |-> !hsi_osc_en_o && !main_osc_en_o)
		else $error("fast oscillators run while system halted");
	a_ppd_pin: assert property (
		sys_rst_n_o && !secondary_ram_bank_pwr_en_o && por_ok_i && !lvd_low_i |=> sys_rst_n_o)
		else $error("internal reset during partial power-down");
	a_por_hold: assert property (!por_ok_i |=> !sys_rst_n_o)
		else $error("internal reset not held with supply low");
	a_lvd_flag: assert property (
		sys_rst_n_o && opt_lvd_irq_mode_i && lvd_low_i |=> lvd_irq_o)
		else $error("detector flag not set in interrupt mode");
	a_lvd_reset: assert property (!opt_lvd_irq_mode_i && lvd_low_i |=> !sys_rst_n_o)
		else $error("detector reset not raised in reset mode");
	a_stab_wait: assert property (
		stab_cnt_reg != 16'h0 && stab_cnt_reg < STAB_CYC |-> !cpu_clk_en_o)
		else $error("cpu clock before crystal settling wait");
	a_stab_end: assert property (stab_cnt_reg == STAB_CYC + 4 |-> cpu_clk_en_o)
		else $error("cpu clock late after settling wait");
	a_lsi_period: assert property (lsi_tick_o && gap_reg <= LSI_DIV |-> gap_reg == LSI_DIV)
		else $error("slow oscillator tick too early");
endmodule
bind ckpm_top ckpm_top_monitor #(.STAB_CYC(STAB_CYC), .LSI_DIV(LSI_DIV)) mon_inst (.*);
`default_nettype wire

/* File: dv/ckpm_core_model.sv */
// partner: processor core model issuing bus cycles and sleep commands
`timescale 1ns/1ps
`default_nettype none
module ckpm_core_model
	import ckpm_pkg::*;
(
	// clock and answer
	input  wire logic  sys_clk_i,
	input  wire logic  wb_ack_i,
	// wishbone master
	output logic       wb_cyc_o,
	output logic       wb_stb_o,
	output logic       wb_we_o,
	output logic [7:0] wb_adr_o,
	output logic [3:0] wb_sel_o,
	output logic [31:0] wb_dat_o
);
	initial {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;

	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge sys_clk_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o  <= we;
		wb_adr_o <= adr;
		wb_sel_o <= 4'hF;
		wb_dat_o <= dat;
		do
			@(posedge sys_clk_i);
		while (wb_ack_i !== 1'b1);
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
	endtask

	// unmask the chosen wake sources, arm the key, then deep sleep
	task automatic enter_ppd(input logic [6:0] mask);
		xfer(1'b1, ADDR_WAKE_MASK, {25'h0, mask});
		xfer(1'b1, ADDR_PWR_KEY, PWR_KEY_VALUE);
		xfer(1'b1, ADDR_CMD, 32'h0000_0002);
	endtask

	// woken by interrupt only; acknowledge by clearing the reinit flag in status
	task automatic reinit();
		xfer(1'b1, ADDR_STATUS, 32'h0000_0001);
	endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// testbench: drives the clock and power-mode controller through bus, supply and wake pins
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ckpm_pkg::*;
	localparam int unsigned STAB = 20;
	logic        sys_clk_i, arst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, por_ok_i;
	logic        lvd_low_i, opt_lvd_irq_mode_i, opt_wdt_irq_mode_i, ext_reset_n_i;
	logic        main_osc_en_o, main_ext_in_en_o, hsi_osc_en_o, sub_osc_en_o;
	logic        sub_ext_in_en_o, lsi_osc_en_o, cpu_clk_en_o, per_clk_en_o, lsi_tick_o;
	logic        secondary_ram_bank_pwr_en_o, per_pwr_en_o, sys_rst_n_o, lvd_irq_o, reinit_req_o;
	logic [1:0]  cpu_src_o;
	logic [3:0]  wb_sel_i;
	logic [6:0]  irq_src_i;
	logic [7:0]  wb_adr_i, opt_hsi_freq_i, hsi_freq_o, freq;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [31:0] exp_q[$];
	integer      seed = 32'h2332;
	int          miscompares = 0;
	int          checks = 0;
	int          cycles = 0;
	int          n;

	ckpm_top #(.STAB_CYC(STAB), .LSI_DIV(4)) ckpm_top_inst (.*);
	ckpm_core_model core (.sys_clk_i(sys_clk_i), .wb_ack_i(wb_ack_o), .wb_cyc_o(wb_cyc_i),
		.wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i),
		.wb_dat_o(wb_dat_i));

	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end

	task automatic print_verdict();
		if (miscompares == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		core.xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		core.xfer(1'b0, a, 32'h0);
	endtask

	task automatic wait_rst();
		n = 0;
		while (sys_rst_n_o !== 1'b1 && n < 100) begin
			@(posedge sys_clk_i);
			n++;
		end
		@(posedge sys_clk_i);
		chk(sys_rst_n_o, 1'b1);
	endtask

	// ****************************************
	// read-data watcher and timeout
	// ****************************************
	always @(posedge sys_clk_i)
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
			chk(wb_dat_o, exp_q.pop_front());

	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			print_verdict();
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		arst_n_i = 1'b0;
		por_ok_i = 1'b1;
		lvd_low_i = 1'b0;
		opt_lvd_irq_mode_i = 1'b1;
		opt_wdt_irq_mode_i = 1'b0;
		ext_reset_n_i = 1'b1;
		irq_src_i = 7'h00;
		opt_hsi_freq_i = 8'($random(seed));
		repeat (2) @(posedge sys_clk_i);
		arst_n_i <= 1'b1;
		wait_rst();
		chk({cpu_clk_en_o, hsi_osc_en_o, lsi_osc_en_o, sub_osc_en_o, cpu_src_o}, 6'h38);
		chk(hsi_freq_o, opt_hsi_freq_i);
		rd(ADDR_CLK_STOP, CLK_STOP_RST);
		rd(ADDR_WAKE_MASK, WMASK_RST);
		rd(8'h1C, 32'h0);
		freq = 8'($random(seed));
		wr(ADDR_HSI_FREQ, freq);
		rd(ADDR_HSI_FREQ, freq);
		chk(hsi_freq_o, freq);
		for (int i = 7; i >= 0; i--) begin
			wr(ADDR_CLK_STOP, i);
			chk({main_osc_en_o, main_ext_in_en_o}, {2{!i[0]}});
			chk(hsi_osc_en_o, !i[1]);
			chk({sub_osc_en_o, sub_ext_in_en_o}, {2{!i[2]}});
		end
		wr(ADDR_WAKE_MASK, 32'h2);
		wr(ADDR_CMD, 32'h1);
		repeat (2) @(posedge sys_clk_i);
		chk({cpu_clk_en_o, per_clk_en_o, main_osc_en_o, hsi_osc_en_o, sub_osc_en_o}, 5'h0F);
		rd(ADDR_STATUS, CKPM_SLEEP << 2);
		irq_src_i <= 7'h40;
		repeat (4) @(posedge sys_clk_i);
		chk(cpu_clk_en_o, 1'b0);
		irq_src_i <= 7'h02;
		repeat (3) @(posedge sys_clk_i);
		chk(cpu_clk_en_o, 1'b1);
		irq_src_i <= 7'h00;
		rd(ADDR_WAKE_MASK, 32'h2);
		wr(ADDR_CPU_CLK, CKPM_SRC_LSI);
		chk(cpu_src_o, CKPM_SRC_LSI);
		wr(ADDR_CPU_CLK, CKPM_SRC_MAIN);
		chk(cpu_src_o, CKPM_SRC_MAIN);
		wr(ADDR_CMD, 32'h2);
		repeat (2) @(posedge sys_clk_i);
		chk({hsi_osc_en_o, main_osc_en_o, main_ext_in_en_o, cpu_clk_en_o}, 4'h0);
		irq_src_i <= 7'h02;
		n = 0;
		while (cpu_clk_en_o !== 1'b1 && n < 100) begin
			@(posedge sys_clk_i);
			n++;
		end
		chk(n > STAB && n < 40, 1'b1);
		irq_src_i <= 7'h00;
		wr(ADDR_CPU_CLK, CKPM_SRC_HSI);
		core.enter_ppd(7'h7F);
		repeat (2) @(posedge sys_clk_i);
		chk({secondary_ram_bank_pwr_en_o, per_pwr_en_o}, 2'h0);
		ext_reset_n_i <= 1'b0;
		irq_src_i <= 7'h50;
		repeat (4) @(posedge sys_clk_i);
		chk({secondary_ram_bank_pwr_en_o, sys_rst_n_o}, 2'h1);
		ext_reset_n_i <= 1'b1;
		irq_src_i <= 7'h00;
		opt_wdt_irq_mode_i <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			if (i > 0)
				core.enter_ppd(7'h01 << i);
			@(posedge sys_clk_i);
			irq_src_i <= 7'h01 << i;
			n = 0;
			while (secondary_ram_bank_pwr_en_o !== 1'b1 && n < 50) begin
				@(posedge sys_clk_i);
				n++;
			end
			chk({per_pwr_en_o, reinit_req_o}, 2'h3);
			irq_src_i <= 7'h00;
			rd(ADDR_STATUS, 32'h1);
			core.reinit();
		end
		rd(ADDR_STATUS, 32'h0);
		lvd_low_i <= 1'b1;
		@(posedge sys_clk_i);
		lvd_low_i <= 1'b0;
		@(posedge sys_clk_i);
		chk(lvd_irq_o, 1'b1);
		rd(ADDR_STATUS, 32'h2);
		wr(ADDR_STATUS, 32'h2);
		rd(ADDR_STATUS, 32'h0);
		opt_lvd_irq_mode_i <= 1'b0;
		lvd_low_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		chk(sys_rst_n_o, 1'b0);
		lvd_low_i <= 1'b0;
		wait_rst();
		por_ok_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		chk(sys_rst_n_o, 1'b0);
		por_ok_i <= 1'b1;
		wait_rst();
		rd(ADDR_HSI_FREQ, opt_hsi_freq_i);
		print_verdict();
	end
endmodule
`default_nettype wire
